// file: rtl/cdaf_core.sv
// Core data access unit: load/store path, register banks, packet decode.
`timescale 1ns/1ns
`default_nettype none
module cdaf_core #(
  parameter int MEM_DEPTH = 64,
  parameter int MEM_AW    = 6
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Access request
  input  wire logic                 req_valid,
  input  wire cdaf_pkg::cdaf_op_t   req_op,
  input  wire cdaf_pkg::cdaf_size_t req_size,
  input  wire logic [31:0]          req_addr,
  input  wire logic [5:0]           req_dst,
  input  wire logic [5:0]           req_src,
  // Instruction packet
  input  wire logic                 pkt_valid,
  input  wire logic [127:0]         pkt_data,
  // Context save strobe
  input  wire logic                 ctx_save,
  // Access response
  output logic                      rsp_valid_ff,
  output logic                      rsp_err_ff,
  output logic      [63:0]          rsp_data_ff,
  // Packet decode result
  output logic                      pkt_done_ff,
  output logic      [3:0]           pkt_count_ff,
  output logic      [4:0]           pkt_bytes_ff,
  output logic                      pkt_err_ff,
  // Status registers
  output logic      [7:0]           decode_phase_status_ff,
  output logic      [7:0]           execute_phase_status_ff,
  output logic      [7:0]           interrupt_context_status_ff
);

  // Banks: 0..15 addressing, 16..31 fixed point, 32..63 floating point.
  logic [63:0] regs_ff  [cdaf_pkg::NUM_REGS];
  logic [63:0] nxt_regs [cdaf_pkg::NUM_REGS];

  logic        nxt_rsp_valid;
  logic        nxt_rsp_err;
  logic [63:0] nxt_rsp_data;
  logic [7:0]  nxt_exs;
  logic [7:0]  nxt_ics;
  logic        nxt_pkt_done;
  logic [3:0]  nxt_pkt_count;
  logic [4:0]  nxt_pkt_bytes;
  logic        nxt_pkt_err;
  logic [7:0]  nxt_dcs;

  logic        misal;
  logic [63:0] src_data;
  logic [63:0] mem_rd;
  logic [63:0] ld_data;
  logic        mem_we;
  logic [63:0] fp_y;
  logic        fp_err;

  assign misal    = cdaf_pkg::misaligned(req_size, req_addr[2:0]);
  assign src_data = regs_ff[req_src];
  assign ld_data  = mem_rd & cdaf_pkg::size_mask(req_size);

  cdaf_mem #(
    .DEPTH   (MEM_DEPTH),
    .AW      (MEM_AW)
  ) u_mem (
    .mclk    (mclk),
    .rst     (rst),
    .wr_en   (mem_we),
    .wr_addr (req_addr[MEM_AW-1:0]),
    .wr_be   (cdaf_pkg::byte_en(req_size)),
    .wr_data (src_data),
    .rd_addr (req_addr[MEM_AW-1:0]),
    .rd_data (mem_rd)
  );

  cdaf_fpu u_fpu (
    .op      (req_op),
    .sz      (req_size),
    .a       (src_data),
    .y       (fp_y),
    .err     (fp_err)
  );

  // Access execution: every request is answered on the next edge.
  always_comb
  begin
    nxt_regs      = regs_ff;
    nxt_rsp_valid = req_valid;
    nxt_rsp_err   = 1'b0;
    nxt_rsp_data  = 64'h0;
    mem_we        = 1'b0;
    nxt_exs       = execute_phase_status_ff;
    nxt_ics       = interrupt_context_status_ff;
    if (req_valid)
    begin
      nxt_exs = cdaf_pkg::STATUS_RST;
      case (req_op)
        cdaf_pkg::OP_LOAD:
        begin
          nxt_exs[cdaf_pkg::EXS_LOAD_BIT] = 1'b1;
          if (misal)
            nxt_rsp_err = 1'b1;
          else
          begin
            nxt_regs[req_dst] = ld_data;
            nxt_rsp_data      = ld_data;
          end
        end
        cdaf_pkg::OP_STORE:
        begin
          nxt_exs[cdaf_pkg::EXS_STORE_BIT] = 1'b1;
          if (misal)
            nxt_rsp_err = 1'b1;
          else
          begin
            mem_we       = 1'b1;
            nxt_rsp_data = src_data & cdaf_pkg::size_mask(req_size);
          end
        end
        cdaf_pkg::OP_MOVE:
        begin
          nxt_exs[cdaf_pkg::EXS_MOVE_BIT] = 1'b1;
          nxt_regs[req_dst] = src_data;
          nxt_rsp_data      = src_data;
        end
        cdaf_pkg::OP_FNEG, cdaf_pkg::OP_FABS:
        begin
          nxt_exs[cdaf_pkg::EXS_FP_BIT] = 1'b1;
          if (fp_err)
            nxt_rsp_err = 1'b1;
          else
          begin
            nxt_regs[req_dst] = fp_y;
            nxt_rsp_data      = fp_y;
          end
        end
        default:
        begin
          nxt_rsp_err = 1'b1;
        end
      endcase
      nxt_exs[cdaf_pkg::EXS_ERR_BIT] = nxt_rsp_err;
    end
    if (ctx_save)
      nxt_ics = execute_phase_status_ff;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      regs_ff                     <= '{default: cdaf_pkg::REG_RST};
      rsp_valid_ff                <= 1'b0;
      rsp_err_ff                  <= 1'b0;
      rsp_data_ff                 <= 64'h0;
      execute_phase_status_ff     <= cdaf_pkg::STATUS_RST;
      interrupt_context_status_ff <= cdaf_pkg::STATUS_RST;
    end
    else
    begin
      regs_ff                     <= nxt_regs;
      rsp_valid_ff                <= nxt_rsp_valid;
      rsp_err_ff                  <= nxt_rsp_err;
      rsp_data_ff                 <= nxt_rsp_data;
      execute_phase_status_ff     <= nxt_exs;
      interrupt_context_status_ff <= nxt_ics;
    end
  end

  // Packet decode: walks halfwords, sizing each instruction from its top bits.
  always_comb
  begin
    int          pos;
    logic        done;
    logic        bad;
    logic [3:0]  cnt;
    logic [15:0] hw;
    logic [1:0]  len;
    pos           = 0;
    done          = 1'b0;
    bad           = 1'b0;
    cnt           = 4'h0;
    hw            = 16'h0;
    len           = 2'h0;
    nxt_pkt_done  = pkt_valid;
    nxt_pkt_count = pkt_count_ff;
    nxt_pkt_bytes = pkt_bytes_ff;
    nxt_pkt_err   = pkt_err_ff;
    nxt_dcs       = decode_phase_status_ff;
    if (pkt_valid)
    begin
      for (int i = 0; i < cdaf_pkg::MAX_ISSUE; i++)
      begin
        if (!done && !bad && pos < cdaf_pkg::PKT_HALFWORDS)
        begin
          hw  = pkt_data[pos*16 +: 16];
          len = hw[cdaf_pkg::ILEN_MSB:cdaf_pkg::ILEN_LSB];
          if (len != cdaf_pkg::ILEN_16 && len != cdaf_pkg::ILEN_32 &&
              len != cdaf_pkg::ILEN_48)
            bad = 1'b1;
          else if (pos + int'(len) + 1 > cdaf_pkg::PKT_HALFWORDS)
            bad = 1'b1;
          else
          begin
            cnt  = cnt + 4'h1;
            pos  = pos + int'(len) + 1;
            done = hw[cdaf_pkg::PKT_END_BIT];
          end
        end
      end
      if (!done)
        bad = 1'b1;
      nxt_pkt_err   = bad;
      nxt_pkt_count = bad ? 4'h0 : cnt;
      nxt_pkt_bytes = bad ? 5'h00 : 5'(pos * 2);
      nxt_dcs       = {3'h0, bad, nxt_pkt_count};
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pkt_done_ff            <= 1'b0;
      pkt_count_ff           <= 4'h0;
      pkt_bytes_ff           <= 5'h00;
      pkt_err_ff             <= 1'b0;
      decode_phase_status_ff <= cdaf_pkg::STATUS_RST;
    end
    else
    begin
      pkt_done_ff            <= nxt_pkt_done;
      pkt_count_ff           <= nxt_pkt_count;
      pkt_bytes_ff           <= nxt_pkt_bytes;
      pkt_err_ff             <= nxt_pkt_err;
      decode_phase_status_ff <= nxt_dcs;
    end
  end

  // Checks of the behaviour above.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic [7:0] st_low;
  logic       eight_short;
  assign st_low = src_data[7:0];

  always_comb
  begin
    eight_short = 1'b1;
    for (int i = 0; i < cdaf_pkg::PKT_HALFWORDS; i++)
      if (pkt_data[i*16+cdaf_pkg::ILEN_LSB +: 2] != cdaf_pkg::ILEN_16 ||
          pkt_data[i*16+cdaf_pkg::PKT_END_BIT] != (i == 7))
        eight_short = 1'b0;
  end

  sequence s_store_word;
    req_valid && req_op == cdaf_pkg::OP_STORE &&
    req_size == cdaf_pkg::SZ_WORD && req_addr[1:0] == 2'h0;
  endsequence

  sequence s_load_byte_back;
    req_valid && req_op == cdaf_pkg::OP_LOAD &&
    req_size == cdaf_pkg::SZ_BYTE && req_addr == $past(req_addr);
  endsequence

  AST_LITTLE_ENDIAN: assert property (
    s_store_word ##1 s_load_byte_back |=> rsp_data_ff[7:0] == $past(st_low, 2))
    else $error("Low byte not found at the lowest address.");

  AST_HALF_ALIGN: assert property (
    req_valid && req_op == cdaf_pkg::OP_LOAD && req_size == cdaf_pkg::SZ_HALF &&
    req_addr[0] |=> rsp_valid_ff && rsp_err_ff)
    else $error("Odd halfword load was not refused.");

  AST_WORD_ALIGN: assert property (
    req_valid && req_op == cdaf_pkg::OP_STORE && req_size == cdaf_pkg::SZ_WORD &&
    req_addr[1:0] != 2'h0 |=> rsp_err_ff && rsp_data_ff == 64'h0)
    else $error("Misaligned word store was not refused.");

  AST_DWORD_ALIGN: assert property (
    req_valid && req_op inside {cdaf_pkg::OP_LOAD, cdaf_pkg::OP_STORE} &&
    req_size == cdaf_pkg::SZ_DWORD |=> rsp_err_ff == (|$past(req_addr[2:0])))
    else $error("Doubleword alignment check is wrong.");

  AST_ONE_CYCLE: assert property (
    req_valid ##1 !req_valid |-> rsp_valid_ff ##1 !rsp_valid_ff)
    else $error("Access answer was not exactly one cycle later.");

  AST_FLOAT_SIGN: assert property (
    req_valid && req_op == cdaf_pkg::OP_FNEG && req_size == cdaf_pkg::SZ_DWORD
    |=> !rsp_err_ff && rsp_data_ff[63] != $past(src_data[63]) &&
        rsp_data_ff[62:0] == $past(src_data[62:0]))
    else $error("Double negate gave a wrong result.");

  AST_BANK_MOVE: assert property (
    req_valid && req_op == cdaf_pkg::OP_MOVE && req_src >= 6'(cdaf_pkg::FIX_BASE) &&
    req_src < 6'(cdaf_pkg::FLT_BASE) && req_dst >= 6'(cdaf_pkg::FLT_BASE)
    |=> rsp_valid_ff && regs_ff[$past(req_dst)] == $past(src_data))
    else $error("Bank move did not land in one cycle.");

  AST_INSTR_SIZES: assert property (
    pkt_valid && pkt_data[cdaf_pkg::ILEN_MSB:cdaf_pkg::ILEN_LSB] == cdaf_pkg::ILEN_48 &&
    pkt_data[cdaf_pkg::PKT_END_BIT]
    |=> pkt_done_ff && !pkt_err_ff && pkt_count_ff == 4'h1 && pkt_bytes_ff == 5'h06)
    else $error("Single six-byte instruction packet misdecoded.");

  AST_EIGHT_ISSUE: assert property (
    pkt_valid && eight_short |=> pkt_count_ff == 4'h8 && pkt_bytes_ff == 5'h10)
    else $error("Eight short instructions did not issue together.");

  AST_STATUS: assert property (
    rsp_valid_ff |-> execute_phase_status_ff[cdaf_pkg::EXS_ERR_BIT] == rsp_err_ff)
    else $error("Execute status disagrees with the last access.");

  AST_CTX_COPY: assert property (
    ctx_save |=> interrupt_context_status_ff == $past(execute_phase_status_ff))
    else $error("Context status is not a copy of the execute status.");

  AST_NO_SPLIT: assert property (
    req_valid && misal && req_op == cdaf_pkg::OP_LOAD
    |=> rsp_err_ff && regs_ff[$past(req_dst)] == $past(regs_ff[req_dst]))
    else $error("Misaligned load changed a register.");

endmodule // cdaf_core
`default_nettype wire

// file: rtl/cdaf_pkg.sv
// Shared types, constants and helpers of the core data access unit.
package cdaf_pkg;

  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DWORD} cdaf_size_t;
  typedef enum logic [2:0] {OP_LOAD, OP_STORE, OP_MOVE, OP_FNEG, OP_FABS} cdaf_op_t;

  localparam int NUM_REGS      = 64;
  localparam int FIX_BASE      = 16;
  localparam int FLT_BASE      = 32;
  localparam int MAX_ISSUE     = 8;
  localparam int PKT_HALFWORDS = 8;
  localparam int ILEN_MSB      = 15;
  localparam int ILEN_LSB      = 14;
  localparam int PKT_END_BIT   = 13;
  localparam logic [1:0] ILEN_16 = 2'h0;
  localparam logic [1:0] ILEN_32 = 2'h1;
  localparam logic [1:0] ILEN_48 = 2'h2;
  localparam int EXS_ERR_BIT   = 0;
  localparam int EXS_LOAD_BIT  = 1;
  localparam int EXS_STORE_BIT = 2;
  localparam int EXS_MOVE_BIT  = 3;
  localparam int EXS_FP_BIT    = 4;
  localparam int DCS_ERR_BIT   = 4;
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [7:0]  MEM_RST    = 8'h00;
  localparam logic [63:0] REG_RST    = 64'h0;

  function automatic logic misaligned(input cdaf_size_t sz, input logic [2:0] a);
    case (sz)
      SZ_HALF:  misaligned = a[0];
      SZ_WORD:  misaligned = |a[1:0];
      SZ_DWORD: misaligned = |a;
      default:  misaligned = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] byte_en(input cdaf_size_t sz);
    case (sz)
      SZ_BYTE: byte_en = 8'h01;
      SZ_HALF: byte_en = 8'h03;
      SZ_WORD: byte_en = 8'h0F;
      default: byte_en = 8'hFF;
    endcase
  endfunction

  function automatic logic [63:0] size_mask(input cdaf_size_t sz);
    logic [7:0] be;
    be = byte_en(sz);
    for (int i = 0; i < 8; i++)
      size_mask[i*8 +: 8] = {8{be[i]}};
  endfunction

endpackage

// file: rtl/cdaf_mem.sv
// Byte-addressed little-endian data memory built from flip-flops.
`timescale 1ns/1ns
`default_nettype none
module cdaf_mem #(
  parameter int DEPTH = 64,
  parameter int AW    = 6
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Write port
  input  wire logic        wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]  wr_be,
  input  wire logic [63:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output logic      [63:0] rd_data
);

  logic [7:0] mem_ff  [DEPTH];
  logic [7:0] nxt_mem [DEPTH];

  // Byte lane i of a datum lives at address plus i, so the low byte sits lowest.
  always_comb
  begin
    nxt_mem = mem_ff;
    if (wr_en)
      for (int i = 0; i < 8; i++)
        if (wr_be[i])
          nxt_mem[AW'(wr_addr + AW'(i))] = wr_data[i*8 +: 8];
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      rd_data[i*8 +: 8] = mem_ff[AW'(rd_addr + AW'(i))];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      mem_ff <= '{default: cdaf_pkg::MEM_RST};
    else
      mem_ff <= nxt_mem;
  end

endmodule // cdaf_mem
`default_nettype wire

// file: rtl/cdaf_fpu.sv
// Sign-handling floating-point unit for single and double IEEE operands.
`timescale 1ns/1ns
`default_nettype none
module cdaf_fpu (
  // Operation
  input  wire cdaf_pkg::cdaf_op_t   op,
  input  wire cdaf_pkg::cdaf_size_t sz,
  input  wire logic [63:0]          a,
  // Result
  output logic      [63:0]          y,
  output logic                      err
);

  logic sgn;

  // Single precision uses the low word; the upper word reads as zero.
  always_comb
  begin
    y   = 64'h0;
    err = 1'b0;
    sgn = (op == cdaf_pkg::OP_FNEG);
    case (sz)
      cdaf_pkg::SZ_WORD:
      begin
        y[31:0] = {sgn ? ~a[31] : 1'b0, a[30:0]};
      end
      cdaf_pkg::SZ_DWORD:
      begin
        y = {sgn ? ~a[63] : 1'b0, a[62:0]};
      end
      default:
      begin
        err = 1'b1;
      end
    endcase
  end

endmodule // cdaf_fpu
`default_nettype wire

// file: tb/cdaf_ref_mem.sv
// Reference model of the byte-addressed data memory behind the core.
`timescale 1ns/1ns
`default_nettype none
module cdaf_ref_mem #(
  parameter int DEPTH = 64
);
  logic [7:0] mem_q [DEPTH];

  initial
  begin
    foreach (mem_q[i])
      mem_q[i] = 8'h00;
  end

  // Writes the low n bytes of d, the least significant byte at the lowest address.
  task automatic put(input int a, input int n, input logic [63:0] d);
    for (int i = 0; i < n; i++)
      mem_q[(a + i) % DEPTH] = d[i*8 +: 8];
  endtask

  // Reads n bytes and zero-extends them to a doubleword.
  function automatic logic [63:0] get(input int a, input int n);
    get = 64'h0;
    for (int i = 0; i < n; i++)
      get[i*8 +: 8] = mem_q[(a + i) % DEPTH];
  endfunction
endmodule // cdaf_ref_mem
`default_nettype wire

// file: tb/test_cpu_data_access_format.sv
// Self-checking bench of the core data access unit.
`timescale 1ns/1ns
`default_nettype none
module test_cpu_data_access_format;
  logic                 mclk;
  logic                 rst;
  logic                 req_valid;
  cdaf_pkg::cdaf_op_t   req_op;
  cdaf_pkg::cdaf_size_t req_size;
  logic [31:0]          req_addr;
  logic [5:0]           req_dst;
  logic [5:0]           req_src;
  logic                 pkt_valid;
  logic [127:0]         pkt_data;
  logic                 ctx_save;
  logic                 rvld;
  logic                 rerr;
  logic [63:0]          rdat;
  logic                 pdone;
  logic [3:0]           pcnt;
  logic [4:0]           pbyt;
  logic                 perr;
  logic [7:0]           dcs;
  logic [7:0]           exs;
  logic [7:0]           ics;
  int                   err_count;
  int                   compares;
  localparam logic [63:0] NEG_D = 64'h8000_0000_0000_0000;
  localparam logic [63:0] NEG_S = 64'h0000_0000_8000_0000;

  cdaf_core #(.MEM_DEPTH(64), .MEM_AW(6)) dut (
    .mclk                        (mclk),
    .rst                         (rst),
    .req_valid                   (req_valid),
    .req_op                      (req_op),
    .req_size                    (req_size),
    .req_addr                    (req_addr),
    .req_dst                     (req_dst),
    .req_src                     (req_src),
    .pkt_valid                   (pkt_valid),
    .pkt_data                    (pkt_data),
    .ctx_save                    (ctx_save),
    .rsp_valid_ff                (rvld),
    .rsp_err_ff                  (rerr),
    .rsp_data_ff                 (rdat),
    .pkt_done_ff                 (pdone),
    .pkt_count_ff                (pcnt),
    .pkt_bytes_ff                (pbyt),
    .pkt_err_ff                  (perr),
    .decode_phase_status_ff      (dcs),
    .execute_phase_status_ff     (exs),
    .interrupt_context_status_ff (ics)
  );

  cdaf_ref_mem #(.DEPTH(64)) rmem ();

  always #4 mclk = ~mclk;

  task automatic stop_test;
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic int nb(input cdaf_pkg::cdaf_size_t sz);
    return 1 << int'(sz);
  endfunction

  // One request, its answer on the next edge, then the answer must drop.
  task automatic acc(input cdaf_pkg::cdaf_op_t op, input cdaf_pkg::cdaf_size_t sz,
                     input int a, input int d, input int s, input logic e,
                     input logic [63:0] x);
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op    <= op;
    req_size  <= sz;
    req_addr  <= 32'(a);
    req_dst   <= 6'(d);
    req_src   <= 6'(s);
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
    chk("rsp_valid", 64'h1, 64'(rvld));
    chk("rsp_err", 64'(e), 64'(rerr));
    chk("rsp_data", x, rdat);
    chk("exec_err", 64'(e), 64'(exs[cdaf_pkg::EXS_ERR_BIT]));
    @(posedge mclk);
    #1;
    chk("rsp_drop", 64'h0, 64'(rvld));
  endtask

  task automatic st(input int a, input cdaf_pkg::cdaf_size_t sz, input int s,
                    input logic [63:0] v);
    logic [63:0] m;
    logic        e;
    e = (a % nb(sz)) != 0;
    m = (64'h1 << (8 * nb(sz))) - 64'h1;
    acc(cdaf_pkg::OP_STORE, sz, a, 0, s, e, e ? 64'h0 : (v & m));
    if (!e)
      rmem.put(a, nb(sz), v);
  endtask

  task automatic ld(input int a, input cdaf_pkg::cdaf_size_t sz);
    logic e;
    e = (a % nb(sz)) != 0;
    acc(cdaf_pkg::OP_LOAD, sz, a, 41, 0, e, e ? 64'h0 : rmem.get(a, nb(sz)));
  endtask

  task automatic t_reset;
    #1;
    chk("rsp_valid", 64'h0, 64'(rvld));
    chk("status", 64'h0, {40'h0, dcs, exs, ics});
  endtask

  task automatic t_fp;
    acc(cdaf_pkg::OP_FNEG, cdaf_pkg::SZ_DWORD, 0, 33, 32, 1'b0, NEG_D);
    acc(cdaf_pkg::OP_FNEG, cdaf_pkg::SZ_WORD, 0, 34, 32, 1'b0, NEG_S);
    acc(cdaf_pkg::OP_FNEG, cdaf_pkg::SZ_WORD, 0, 35, 33, 1'b0, NEG_S);
    acc(cdaf_pkg::OP_FABS, cdaf_pkg::SZ_DWORD, 0, 36, 33, 1'b0, 64'h0);
    acc(cdaf_pkg::OP_FABS, cdaf_pkg::SZ_WORD, 0, 36, 34, 1'b0, 64'h0);
    acc(cdaf_pkg::OP_FNEG, cdaf_pkg::SZ_HALF, 0, 37, 32, 1'b1, 64'h0);
    acc(cdaf_pkg::OP_FABS, cdaf_pkg::SZ_BYTE, 0, 37, 32, 1'b1, 64'h0);
  endtask

  task automatic t_move;
    acc(cdaf_pkg::OP_MOVE, cdaf_pkg::SZ_DWORD, 0, 20, 33, 1'b0, NEG_D);
    acc(cdaf_pkg::OP_MOVE, cdaf_pkg::SZ_DWORD, 0, 21, 34, 1'b0, NEG_S);
    acc(cdaf_pkg::OP_MOVE, cdaf_pkg::SZ_DWORD, 0, 38, 20, 1'b0, NEG_D);
  endtask

  // Store then two byte loads on back-to-back edges; each sees the bytes just written.
  task automatic t_b2b;
    @(posedge mclk);
    req_valid <= 1'b1;
    req_op    <= cdaf_pkg::OP_STORE;
    req_size  <= cdaf_pkg::SZ_WORD;
    req_addr  <= 32'h20;
    req_src   <= 6'h22;
    rmem.put(32, 4, NEG_S);
    @(posedge mclk);
    req_op    <= cdaf_pkg::OP_LOAD;
    req_size  <= cdaf_pkg::SZ_BYTE;
    req_dst   <= 6'h2A;
    #1;
    chk("b2b_store", NEG_S, rdat);
    @(posedge mclk);
    req_addr  <= 32'h23;
    #1;
    chk("b2b_low", rmem.get(32, 1), rdat);
    @(posedge mclk);
    req_valid <= 1'b0;
    #1;
    chk("b2b_high", rmem.get(35, 1), rdat);
    chk("b2b_valid", 64'h1, 64'(rvld));
    @(posedge mclk);
    #1;
    chk("b2b_drop", 64'h0, 64'(rvld));
  endtask

  task automatic t_le;
    int la[8] = '{8, 15, 14, 12, 16, 18, 19, 23};
    int lz[8] = '{3, 0, 1, 2, 3, 1, 0, 0};
    st(8, cdaf_pkg::SZ_DWORD, 38, NEG_D);
    st(16, cdaf_pkg::SZ_WORD, 21, NEG_S);
    st(20, cdaf_pkg::SZ_WORD, 21, NEG_S);
    st(30, cdaf_pkg::SZ_HALF, 20, NEG_D);
    foreach (la[i])
      ld(la[i], cdaf_pkg::cdaf_size_t'(lz[i]));
  endtask

  task automatic t_align;
    for (int z = 1; z < 4; z++)
      for (int a = 1; a < 8; a++)
        ld(8 + a, cdaf_pkg::cdaf_size_t'(z));
    st(9, cdaf_pkg::SZ_DWORD, 21, NEG_S);
    st(18, cdaf_pkg::SZ_WORD, 20, NEG_D);
    st(17, cdaf_pkg::SZ_HALF, 20, NEG_D);
    ld(8, cdaf_pkg::SZ_DWORD);
    ld(16, cdaf_pkg::SZ_DWORD);
    acc(cdaf_pkg::cdaf_op_t'(3'h5), cdaf_pkg::SZ_BYTE, 0, 1, 2, 1'b1, 64'h0);
  endtask

  task automatic t_ctx;
    st(0, cdaf_pkg::SZ_WORD, 21, NEG_S);
    chk("exec_status", 64'h1 << cdaf_pkg::EXS_STORE_BIT, 64'(exs));
    @(posedge mclk);
    ctx_save <= 1'b1;
    @(posedge mclk);
    ctx_save <= 1'b0;
    #1;
    chk("ctx_status", 64'h1 << cdaf_pkg::EXS_STORE_BIT, 64'(ics));
    ld(3, cdaf_pkg::SZ_WORD);
    chk("ctx_hold", 64'h1 << cdaf_pkg::EXS_STORE_BIT, 64'(ics));
  endtask

  task automatic pk(input logic [127:0] p, input int c, input int b, input logic e);
    @(posedge mclk);
    pkt_valid <= 1'b1;
    pkt_data  <= p;
    @(posedge mclk);
    pkt_valid <= 1'b0;
    #1;
    chk("pkt_done", 64'h1, 64'(pdone));
    chk("pkt_result", 64'({e, 4'(c), 5'(b)}), 64'({perr, pcnt, pbyt}));
    chk("decode_status", 64'({3'h0, e, 4'(c)}), 64'(dcs));
    @(posedge mclk);
    #1;
    chk("pkt_hold", 64'({1'b0, e, 4'(c), 5'(b)}), 64'({pdone, perr, pcnt, pbyt}));
  endtask

  task automatic t_pkt;
    pk(128'h2000, 1, 2, 1'b0);
    pk({16'h2000, 112'h0}, 8, 16, 1'b0);
    pk(128'h0000_A000_0000_4000, 2, 10, 1'b0);
    pk(128'hA000, 1, 6, 1'b0);
    pk(128'hE000, 0, 0, 1'b1);
    pk(128'h0, 0, 0, 1'b1);
    pk({16'h0, 16'hA000, 96'h0}, 0, 0, 1'b1);
  endtask

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count++;
    stop_test();
  end

  initial
  begin
    mclk      = 1'b0;
    rst       = 1'b1;
    req_valid = 1'b0;
    req_op    = cdaf_pkg::OP_LOAD;
    req_size  = cdaf_pkg::SZ_BYTE;
    req_addr  = 32'h0;
    req_dst   = 6'h0;
    req_src   = 6'h0;
    pkt_valid = 1'b0;
    pkt_data  = 128'h0;
    ctx_save  = 1'b0;
    err_count = 0;
    compares  = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_fp();
    t_move();
    t_b2b();
    t_le();
    t_align();
    t_ctx();
    t_pkt();
    stop_test();
  end
endmodule // test_cpu_data_access_format
`default_nettype wire
